/* File: shared/rsac_pkg.sv */
/*
  Constants for the seconds/alarm clock core: register byte addresses,
  control field positions, divider and update-cycle counts.
  Assumes a 32-bit APB with full byte addresses on paddr.
*/
package rsac_pkg;

  localparam logic [31:0] RSAC_ADDR_CTRL    = 32'h700CC000;
  localparam logic [31:0] RSAC_ADDR_ALARM   = 32'h700CC004;
  localparam logic [31:0] RSAC_ADDR_SECONDS = 32'h700CC008;
  localparam logic [31:0] RSAC_ADDR_DIVIDER = 32'h700CC00C;

  localparam int RSAC_CNT_W = 29;
  localparam int RSAC_DIV_W = 15;

  // Control register field positions; RSAC_B_UPDATE_BUSY is a seconds read bit
  localparam int RSAC_B_CLK_SEL      = 0;
  localparam int RSAC_B_COUNT_EN     = 1;
  localparam int RSAC_B_ALARM_FLAG   = 2;
  localparam int RSAC_B_BAD_WRITE    = 3;
  localparam int RSAC_B_EXT_CLK_SEL  = 4;
  localparam int RSAC_B_CLKOUT_EN    = 5;
  localparam int RSAC_B_CLKOUT_MODE  = 6;
  localparam int RSAC_B_OSC_POWER    = 7;
  localparam int RSAC_B_ALARM_EN     = 9;
  localparam int RSAC_B_ALARM_MODE   = 10;
  localparam int RSAC_B_UPDATE_BUSY  = 31;

  // Writable, stored control bits (flags handled apart)
  localparam logic [31:0] RSAC_CTRL_WMASK = 32'h000006F3;

  localparam logic [14:0] RSAC_DIV_MAX    = 15'h7FFF;
  localparam logic [14:0] RSAC_DIV_ZERO   = 15'h0000;
  // Update cycle length in RTC clock periods
  localparam logic [2:0]  RSAC_UPD_CYCLES = 3'h4;
  localparam logic [2:0]  RSAC_UPD_IDLE   = 3'h0;

endpackage : rsac_pkg

/* File: hdl/rsac_sync.sv */
/*
  Two-flop synchroniser for a bundle of unrelated pin levels.
  Assumes each bit is an independent slow level or clock below CORE_CLK/4.
*/
`timescale 1ns/10ps
module rsac_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : rsac_sync

/* File: hdl/rsac_pin_ctrl.sv */
/*
  Three-state pin control: direct enable bit or follow the reset pin.
  Assumes rst_pin_s is already synchronised; oe_n low means driving.
*/
`timescale 1ns/10ps
module rsac_pin_ctrl (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic mode_bit,
  input  wire logic enable_bit,
  input  wire logic rst_pin_s,
  input  wire logic value,
  output logic      pin_out,
  output logic      pin_oe_n
);

  logic drive;

  assign drive = mode_bit ? rst_pin_s : enable_bit;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_out  <= 1'b1;
      pin_oe_n <= 1'b1;
    end
    else
    begin
      pin_out  <= value;
      pin_oe_n <= !drive;
    end
  end

endmodule : rsac_pin_ctrl

/* File: hdl/rsac_core.sv */
/*
  Seconds/alarm real-time clock core with APB register access, a 15-bit
  sub-second divider, 29-bit seconds counter, alarm compare and two
  three-state pins. Assumes one core clock; crystal, oscillator and reset
  pins arrive asynchronously and are far slower than CORE_CLK.
*/
// The APB register port was chosen for this implementation.
// Summary of operation
// - Mode 0: alarm pin follows enable bit
// - Mode 1: alarm pin follows reset pin
// - Mode 0: clock pin follows enable bit
// - Mode 1: clock pin follows reset pin
// - Alarm equal to seconds requests interrupt
// - Alarm match sets alarm status flag
// - Alarm register holds 29-bit seconds
// - Seconds counter advances once per second
// - Read shows busy bit during update
// - Divider counts 1/32768 second input clocks
// - Control bits choose divider clock source
// - Seconds write clears the divider
// - Divider writable only while counting disabled
// - Divider write while counting flags error
// - Seconds write during update flags, interrupts
// - Status flags clear by writing one
// - Core reset leaves clock registers untouched
// - Select bits: system, oscillator, external clock
`timescale 1ns/10ps
module rsac_core (
  input  wire logic        CORE_CLK,
  input  wire logic        NRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        XTAL_IN,
  input  wire logic        OSC_CLK_IN,
  input  wire logic        CHIP_RESET_PIN_N,
  output logic             CLOCK_IRQ_LINE,
  output logic             OSC_POWER,
  output logic             ALARM_OUT_N,
  output logic             ALARM_OUT_N_OE_N,
  output logic             CLK_OUT_32K,
  output logic             CLK_OUT_32K_OE_N
);
  import rsac_pkg::*;

  logic [31:0]           ctrl_reg;
  logic [RSAC_CNT_W-1:0] alarm_value_reg;
  logic [RSAC_CNT_W-1:0] count_value_reg;
  logic [RSAC_DIV_W-1:0] tick_count_reg;
  logic [2:0]            upd_cnt_reg;
  logic                  src_prev_reg;
  logic [31:0]           rdata_reg;
  logic                  addr_err_reg;
  logic [2:0]            pins_s;
  logic                  xtal_s;
  logic                  osc_s;
  logic                  rst_pin_s;
  logic                  src_level;
  logic                  tick;
  logic                  count_en;
  logic                  wrap;
  logic                  update_busy;
  logic                  wr_acc;
  logic                  wr_ctrl;
  logic                  wr_alarm;
  logic                  wr_sec;
  logic                  wr_div;
  logic                  sec_ok;
  logic                  sec_bad;
  logic                  div_ok;
  logic                  div_bad;
  logic                  alarm_hit;
  logic                  mapped;
  logic [RSAC_CNT_W-1:0] count_next;

  rsac_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk      (CORE_CLK),
    .nrst     (NRST),
    .async_in ({CHIP_RESET_PIN_N, OSC_CLK_IN, XTAL_IN}),
    .sync_out (pins_s)
  );

  assign xtal_s    = pins_s[0];
  assign osc_s     = pins_s[1];
  assign rst_pin_s = pins_s[2];

  // Clock source: system clock gives a tick every cycle (test use)
  assign src_level = ctrl_reg[RSAC_B_EXT_CLK_SEL] ? xtal_s : osc_s;
  assign count_en  = ctrl_reg[RSAC_B_COUNT_EN];

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      src_prev_reg <= 1'b0;
    else
      src_prev_reg <= src_level;
  end

  assign tick = ctrl_reg[RSAC_B_CLK_SEL] ? (src_level && !src_prev_reg)
                                         : 1'b1;
  assign wrap = tick && count_en &&
                (tick_count_reg == RSAC_DIV_MAX);
  assign count_next  = count_value_reg + 29'h00000001;
  assign update_busy = (upd_cnt_reg != RSAC_UPD_IDLE);
  assign alarm_hit   = wrap && (count_next == alarm_value_reg);

  // APB decode; writes take effect in the access phase
  assign wr_acc   = PSEL && PENABLE && PWRITE;
  assign wr_ctrl  = wr_acc && (PADDR == RSAC_ADDR_CTRL);
  assign wr_alarm = wr_acc && (PADDR == RSAC_ADDR_ALARM);
  assign wr_sec   = wr_acc && (PADDR == RSAC_ADDR_SECONDS);
  assign wr_div   = wr_acc && (PADDR == RSAC_ADDR_DIVIDER);
  assign sec_ok   = wr_sec && !update_busy;
  assign sec_bad  = wr_sec && update_busy;
  assign div_ok   = wr_div && !count_en;
  assign div_bad  = wr_div && count_en;
  assign mapped   = (PADDR == RSAC_ADDR_CTRL) ||
                    (PADDR == RSAC_ADDR_ALARM) ||
                    (PADDR == RSAC_ADDR_SECONDS) ||
                    (PADDR == RSAC_ADDR_DIVIDER);

  assign PREADY  = PSEL && PENABLE;
  assign PSLVERR = PSEL && PENABLE && addr_err_reg;
  assign PRDATA  = rdata_reg;

  // Clock registers are on the backup supply: no core reset here
  always_ff @(posedge CORE_CLK)
  begin
    if (wr_ctrl)
      ctrl_reg[10:4] <= PWDATA[10:4] & RSAC_CTRL_WMASK[10:4];
    if (wr_ctrl)
      ctrl_reg[1:0] <= PWDATA[1:0];
    ctrl_reg[31:11] <= '0;
    ctrl_reg[8]     <= 1'b0;
    // Set beats the write-one clear in the same cycle
    if (alarm_hit)
      ctrl_reg[RSAC_B_ALARM_FLAG] <= 1'b1;
    else if (wr_ctrl && PWDATA[RSAC_B_ALARM_FLAG])
      ctrl_reg[RSAC_B_ALARM_FLAG] <= 1'b0;
    if (div_bad || sec_bad)
      ctrl_reg[RSAC_B_BAD_WRITE] <= 1'b1;
    else if (wr_ctrl && PWDATA[RSAC_B_BAD_WRITE])
      ctrl_reg[RSAC_B_BAD_WRITE] <= 1'b0;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (wr_alarm)
      alarm_value_reg <= PWDATA[RSAC_CNT_W-1:0];
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (sec_ok)
      count_value_reg <= PWDATA[RSAC_CNT_W-1:0];
    else if (wrap)
      count_value_reg <= count_next;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (sec_ok)
      tick_count_reg <= RSAC_DIV_ZERO;
    else if (div_ok)
      tick_count_reg <= PWDATA[RSAC_DIV_W-1:0];
    else if (tick && count_en)
      tick_count_reg <= tick_count_reg + 15'h0001;
  end

  // Update window spans four source clock periods after a wrap
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
      upd_cnt_reg <= RSAC_UPD_IDLE;
    else if (wrap)
      upd_cnt_reg <= RSAC_UPD_CYCLES;
    else if (tick && update_busy)
      upd_cnt_reg <= upd_cnt_reg - 3'h1;
  end

  // Read data captured in the setup phase, held through the access
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rdata_reg    <= 32'h00000000;
      addr_err_reg <= 1'b0;
    end
    else if (PSEL && !PENABLE)
    begin
      addr_err_reg <= !mapped;
      case (PADDR)
        RSAC_ADDR_CTRL:
          rdata_reg <= ctrl_reg;
        RSAC_ADDR_ALARM:
          rdata_reg <= {3'h0, alarm_value_reg};
        RSAC_ADDR_SECONDS:
          rdata_reg <= {update_busy, 2'h0, count_value_reg};
        RSAC_ADDR_DIVIDER:
          rdata_reg <= {17'h00000, tick_count_reg};
        default:
          rdata_reg <= 32'h00000000;
      endcase
    end
  end

  // Level request; the interrupt controller applies its own enable
  assign CLOCK_IRQ_LINE = ctrl_reg[RSAC_B_ALARM_FLAG] ||
                          ctrl_reg[RSAC_B_BAD_WRITE];
  assign OSC_POWER      = ctrl_reg[RSAC_B_OSC_POWER];

  rsac_pin_ctrl u_alarm_pin (
    .clk        (CORE_CLK),
    .nrst       (NRST),
    .mode_bit   (ctrl_reg[RSAC_B_ALARM_MODE]),
    .enable_bit (ctrl_reg[RSAC_B_ALARM_EN]),
    .rst_pin_s  (rst_pin_s),
    .value      (!ctrl_reg[RSAC_B_ALARM_FLAG]),
    .pin_out    (ALARM_OUT_N),
    .pin_oe_n   (ALARM_OUT_N_OE_N)
  );

  rsac_pin_ctrl u_clk_pin (
    .clk        (CORE_CLK),
    .nrst       (NRST),
    .mode_bit   (ctrl_reg[RSAC_B_CLKOUT_MODE]),
    .enable_bit (ctrl_reg[RSAC_B_CLKOUT_EN]),
    .rst_pin_s  (rst_pin_s),
    .value      (src_level),
    .pin_out    (CLK_OUT_32K),
    .pin_oe_n   (CLK_OUT_32K_OE_N)
  );

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);

  sequence s_wrap_seen;
    wrap ##1 1'b1;
  endsequence

  AST_ALARM_PIN_DIRECT: assert property (
    !ctrl_reg[RSAC_B_ALARM_MODE] |=>
      (ALARM_OUT_N_OE_N == !$past(ctrl_reg[RSAC_B_ALARM_EN])))
    else $error("alarm pin ignores enable bit");

  AST_ALARM_PIN_RESET: assert property (
    ctrl_reg[RSAC_B_ALARM_MODE] |=> (ALARM_OUT_N_OE_N == !$past(rst_pin_s)))
    else $error("alarm pin ignores reset pin");

  AST_CLK_PIN_DIRECT: assert property (
    !ctrl_reg[RSAC_B_CLKOUT_MODE] |=>
      (CLK_OUT_32K_OE_N == !$past(ctrl_reg[RSAC_B_CLKOUT_EN])))
    else $error("clock pin ignores enable bit");

  AST_CLK_PIN_RESET: assert property (
    ctrl_reg[RSAC_B_CLKOUT_MODE] |=>
      (CLK_OUT_32K_OE_N == !$past(rst_pin_s)) &&
      (CLK_OUT_32K == $past(src_level)))
    else $error("clock pin ignores reset pin");

  AST_ALARM_MATCH: assert property (
    alarm_hit |=> ctrl_reg[RSAC_B_ALARM_FLAG] && CLOCK_IRQ_LINE)
    else $error("alarm match did not set flag");

  AST_WRAP_INCR: assert property (
    (wrap && !sec_ok) |-> s_wrap_seen ##0
      (count_value_reg == $past(count_next)) &&
      (tick_count_reg == RSAC_DIV_ZERO) && update_busy)
    else $error("wrap did not advance seconds");

  AST_SEC_WRITE_CLEARS: assert property (
    sec_ok |=> (tick_count_reg == RSAC_DIV_ZERO) &&
      (count_value_reg == $past(PWDATA[RSAC_CNT_W-1:0])))
    else $error("seconds write did not clear divider");

  AST_DIV_BAD_WRITE: assert property (
    div_bad |=> ctrl_reg[RSAC_B_BAD_WRITE] && CLOCK_IRQ_LINE)
    else $error("illegal divider write not flagged");

  AST_SEC_BUSY_WRITE: assert property (
    sec_bad |=> ctrl_reg[RSAC_B_BAD_WRITE] &&
      (count_value_reg == $past(count_value_reg)))
    else $error("seconds write during update taken");

  AST_READ_BUSY: assert property (
    (PSEL && !PENABLE && (PADDR == RSAC_ADDR_SECONDS)) |=>
      (PRDATA[RSAC_B_UPDATE_BUSY] == $past(update_busy)))
    else $error("busy bit wrong on seconds read");

  AST_FLAG_W0_KEEPS: assert property (
    (wr_ctrl && !PWDATA[RSAC_B_ALARM_FLAG] &&
     ctrl_reg[RSAC_B_ALARM_FLAG]) |=> ctrl_reg[RSAC_B_ALARM_FLAG])
    else $error("alarm flag cleared by writing zero");

endmodule : rsac_core

/* File: verification/tb.sv */
/*
  Self-checking bench for rsac_core: APB register traffic, alarm,
  illegal writes, clock source select and pin three-state control.
  Assumes zero-wait APB and the package constants of rsac_pkg.
*/
`timescale 1ns/10ps
module tb;
  import rsac_pkg::*;
  logic        CORE_CLK = 0, NRST = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [31:0] PADDR = 0, PWDATA = 0, PRDATA;
  logic        PREADY, PSLVERR, XTAL_IN = 0, OSC_CLK_IN = 0;
  logic        CHIP_RESET_PIN_N = 1, CLOCK_IRQ_LINE, OSC_POWER;
  logic        ALARM_OUT_N, ALARM_OUT_N_OE_N, CLK_OUT_32K, CLK_OUT_32K_OE_N;
  int          mismatches = 0, checks_done = 0, n;
  logic [31:0] r, s, d, x;
  logic        err, busy_seen = 1'b0;

  rsac_core i_dut (.CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .XTAL_IN(XTAL_IN), .OSC_CLK_IN(OSC_CLK_IN),
    .CHIP_RESET_PIN_N(CHIP_RESET_PIN_N), .CLOCK_IRQ_LINE(CLOCK_IRQ_LINE),
    .OSC_POWER(OSC_POWER), .ALARM_OUT_N(ALARM_OUT_N),
    .ALARM_OUT_N_OE_N(ALARM_OUT_N_OE_N), .CLK_OUT_32K(CLK_OUT_32K),
    .CLK_OUT_32K_OE_N(CLK_OUT_32K_OE_N));

  always #5 CORE_CLK = ~CORE_CLK;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Request held until PREADY is seen high at a rising edge
  task automatic apb(input logic w, input logic [31:0] a, wd);
    int k;
    k = 0;
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge CORE_CLK);
      k++;
    end
    while (PREADY !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      mismatches++;
      stop_test();
    end
    r = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic pulse(input int sel, input int cnt);
    repeat (cnt)
    begin
      @(posedge CORE_CLK);
      if (sel != 0) XTAL_IN <= 1'b1;
      else OSC_CLK_IN <= 1'b1;
      repeat (4) @(posedge CORE_CLK);
      XTAL_IN <= 1'b0;
      OSC_CLK_IN <= 1'b0;
      repeat (4) @(posedge CORE_CLK);
    end
  endtask : pulse

  initial
  begin
    x = $urandom(32'h6ECAEE87);
    repeat (4) @(posedge CORE_CLK);
    NRST <= 1'b1;
    // Flags power up unknown: clear them before anything else
    apb(1, RSAC_ADDR_CTRL, 32'h0000000C);
    s = $urandom_range(0, 32'h1FFFFFF0);
    apb(1, RSAC_ADDR_SECONDS, s);
    apb(0, RSAC_ADDR_DIVIDER, 0);
    chk("div_clear", r, 32'h00000000);
    d = $urandom_range(0, 32'h7FFF);
    apb(1, RSAC_ADDR_DIVIDER, d);
    apb(0, RSAC_ADDR_DIVIDER, 0);
    chk("div_rw", r, d);
    apb(1, RSAC_ADDR_DIVIDER, 32'h00007FF0);
    apb(1, RSAC_ADDR_ALARM, s + 1);
    apb(1, RSAC_ADDR_CTRL, 32'h00000002);
    n = 0;
    do
    begin
      apb(0, RSAC_ADDR_SECONDS, 0);
      if (r[31] === 1'b1)
        busy_seen = 1'b1;
      n++;
    end
    while (r !== s + 1 && n < 60);
    chk("sec_inc", r, s + 1);
    // Reads come every third cycle, so one lands in the 4-tick window
    chk("busy_seen", 32'(busy_seen), 1);
    apb(0, RSAC_ADDR_CTRL, 0);
    chk("alarm_flag", 32'(r[2]), 1);
    chk("irq_alarm", 32'(CLOCK_IRQ_LINE), 1);
    apb(1, RSAC_ADDR_DIVIDER, 0);
    apb(0, RSAC_ADDR_CTRL, 0);
    chk("bad_write", 32'(r[3]), 1);
    apb(1, RSAC_ADDR_CTRL, 0);
    apb(0, RSAC_ADDR_CTRL, 0);
    chk("flags_kept", 32'(r[3:2]), 3);
    apb(1, RSAC_ADDR_CTRL, 32'h0000000C);
    apb(0, RSAC_ADDR_CTRL, 0);
    chk("flags_clr", 32'(r[3:2]), 0);
    chk("irq_clr", 32'(CLOCK_IRQ_LINE), 0);
    // Seconds write timed to land inside the update window
    apb(1, RSAC_ADDR_DIVIDER, 32'h00007FF0);
    apb(1, RSAC_ADDR_CTRL, 32'h00000002);
    repeat (15) @(posedge CORE_CLK);
    d = $urandom_range(0, 32'h1FFFFFFF);
    apb(1, RSAC_ADDR_SECONDS, d);
    apb(0, RSAC_ADDR_CTRL, 0);
    chk("busy_write", 32'(r[3]), 1);
    chk("irq_busy", 32'(CLOCK_IRQ_LINE), 1);
    apb(0, RSAC_ADDR_SECONDS, 0);
    chk("sec_kept", r, s + 2);
    apb(1, RSAC_ADDR_SECONDS, d);
    apb(0, RSAC_ADDR_SECONDS, 0);
    chk("sec_retry", r, d);
    apb(1, RSAC_ADDR_CTRL, 32'h0000000C);
    apb(1, RSAC_ADDR_ALARM, 32'hFFFFFFFF);
    @(posedge CORE_CLK);
    NRST <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    NRST <= 1'b1;
    apb(0, RSAC_ADDR_ALARM, 0);
    chk("alarm_keep", r, 32'h1FFFFFFF);
    for (int e = 0; e < 2; e++)
    begin
      apb(1, RSAC_ADDR_CTRL, 32'h00000001 | (e << 4));
      apb(1, RSAC_ADDR_DIVIDER, 0);
      apb(1, RSAC_ADDR_CTRL, 32'h00000003 | (e << 4));
      // Unselected source must not move the divider
      pulse(1 - e, 2);
      pulse(e, 3);
      repeat (6) @(posedge CORE_CLK);
      apb(0, RSAC_ADDR_DIVIDER, 0);
      chk("div_source", r, 3);
    end
    for (int i = 0; i < 8; i++)
    begin
      @(posedge CORE_CLK);
      CHIP_RESET_PIN_N <= i[0];
      OSC_CLK_IN <= i[1];
      apb(1, RSAC_ADDR_CTRL, (i[2:1] << 9) | (i[2:1] << 5));
      repeat (6) @(posedge CORE_CLK);
      d = 32'(!(i[2] ? i[0] : i[1]));
      chk("alarm_oe", 32'(ALARM_OUT_N_OE_N), d);
      chk("clk_oe", 32'(CLK_OUT_32K_OE_N), d);
      if (d == 0) chk("alarm_lvl", 32'(ALARM_OUT_N), 1);
      if (d == 0) chk("clk_lvl", 32'(CLK_OUT_32K), 32'(i[1]));
    end
    apb(0, RSAC_ADDR_DIVIDER + 4, 0);
    chk("unmapped_err", 32'(err), 1);
    chk("unmapped_rd", r, 0);
    stop_test();
  end
endmodule : tb
